/* File: verilog/fomle_pkg.sv */
// Contract
// - or-with-file ors accumulator with data byte
// - dest bit 0 writes accumulator, 1 writes file
// - access bit 0 uses access bank, 1 bank register
// - eight-bit field reaches whole 256-byte bank
// - move-file copies byte unchanged to destination
// - byte ops are one word, one cycle
// - load-pointer puts 12-bit literal into pointer 0-2
// - load-pointer: two cycles, high nibble then low byte
// - load-pointer words: ee,00,sel,k11-8 then f0,k7-0
// - load-pointer leaves all status flags unchanged
// - mem-to-mem move copies from any 12-bit address to any unprotected 12-bit address
// - mem-to-mem words begin with 1100 then 1111
// - mem-to-mem: two cycles, protected destinations refused
package fomle_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int          DATA_W       = 8;        // data path width
  localparam int          ADDR_W       = 12;       // data space address width
  localparam int          PTR_CNT      = 3;        // indirect pointers

  // ----------------------------------------------------------------
  // opcode prefixes and field positions
  // ----------------------------------------------------------------
  localparam logic [5:0]  PFX_OR_FILE  = 6'h04;    // 0001 00
  localparam logic [5:0]  PFX_MOV_FILE = 6'h14;    // 0101 00
  localparam logic [7:0]  PFX_LP_W1    = 8'hee;    // 1110 1110
  localparam logic [1:0]  PFX_LP_PAD   = 2'h0;     // 00 before select
  localparam logic [7:0]  PFX_LP_W2    = 8'hf0;    // 1111 0000
  localparam logic [3:0]  PFX_MM_SRC   = 4'hc;     // 1100
  localparam logic [3:0]  PFX_MM_DST   = 4'hf;     // 1111
  localparam int          BIT_DEST     = 9;        // destination select
  localparam int          BIT_ACCESS   = 8;        // access select

  // ----------------------------------------------------------------
  // access bank split and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;    // low half / high half
  localparam logic [3:0]  ACCESS_LO_BK = 4'h0;     // bank of low half
  localparam logic [3:0]  ACCESS_HI_BK = 4'hf;     // bank of high half
  localparam logic [7:0]  ACCUM_RST    = 8'h00;    // accumulator at reset
  localparam logic [11:0] PTR_RST      = 12'h000;  // pointers at reset
  localparam logic [11:0] ADDR_RST     = 12'h000;  // bus address at reset

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} fomle_phase_type;
  typedef enum logic [1:0] {ST_IDLE, ST_LP2, ST_MM2} fomle_state_type;
  typedef enum logic [2:0] {OP_NONE, OP_OR, OP_MOV, OP_LP, OP_MM} fomle_op_type;

  // builds the 12-bit data address of a byte-oriented operand
  function automatic logic [11:0] fomle_bank_addr(input logic       acc,
                                                  input logic [3:0] bank,
                                                  input logic [7:0] f);
    if (acc) begin
      fomle_bank_addr = {bank, f};
    end else if (f < ACCESS_SPLIT) begin
      fomle_bank_addr = {ACCESS_LO_BK, f};
    end else begin
      fomle_bank_addr = {ACCESS_HI_BK, f};
    end
  endfunction : fomle_bank_addr

endpackage : fomle_pkg

/* File: verilog/fomle_core_if.sv */
// carries decode fields and alu operands between the core modules
interface fomle_core_if;
  import fomle_pkg::*;

  logic [15:0]  instr;     // instruction word under decode
  fomle_op_type op;        // decoded first-word operation
  logic         dest;      // destination select
  logic         access;    // access select
  logic [7:0]   faddr;     // 8-bit file address
  logic [1:0]   ptr_sel;   // pointer select
  logic [11:0]  lit_addr;  // literal / 12-bit address field
  logic         word2_lp;  // word is a valid load-pointer second word
  logic         word2_mm;  // word is a valid mem-to-mem second word
  logic [7:0]   accum;     // alu operand a
  logic [7:0]   operand;   // alu operand b (data byte)
  logic         is_or;     // alu ors when high, passes b when low
  logic [7:0]   result;    // alu result
  logic         neg;       // result bit 7
  logic         zero;      // result is zero

  modport dec_mp (input instr, output op, dest, access, faddr, ptr_sel, lit_addr,
                  word2_lp, word2_mm);
  modport alu_mp (input accum, operand, is_or, output result, neg, zero);
  modport exe_mp (output instr, accum, operand, is_or,
                  input op, dest, access, faddr, ptr_sel, lit_addr, word2_lp,
                  word2_mm, result, neg, zero);
endinterface : fomle_core_if

/* File: verilog/fomle_decode.sv */
// combinational field decode of one instruction word
module fomle_decode
  import fomle_pkg::*;
(
  fomle_core_if.dec_mp dif
);

  // ----------------------------------------------------------------
  // opcode match
  // ----------------------------------------------------------------
  always_comb begin
    dif.dest     = dif.instr[BIT_DEST];
    dif.access   = dif.instr[BIT_ACCESS];
    dif.faddr    = dif.instr[7:0];
    dif.ptr_sel  = dif.instr[5:4];
    // load-pointer first word holds k11..8 in the low nibble, others 12 bits
    dif.lit_addr = dif.instr[11:0];
    dif.word2_lp = (dif.instr[15:8] == PFX_LP_W2);
    dif.word2_mm = (dif.instr[15:12] == PFX_MM_DST);
    if (dif.instr[15:10] == PFX_OR_FILE) begin
      dif.op = OP_OR;
    end else if (dif.instr[15:10] == PFX_MOV_FILE) begin
      dif.op = OP_MOV;
    end else if (dif.instr[15:8] == PFX_LP_W1 && dif.instr[7:6] == PFX_LP_PAD) begin
      dif.op = OP_LP;
    end else if (dif.instr[15:12] == PFX_MM_SRC) begin
      dif.op = OP_MM;
    end else begin
      dif.op = OP_NONE;                 // other groups are not ours
    end
  end

endmodule : fomle_decode

/* File: verilog/fomle_alu.sv */
// or / pass-through unit with negative and zero result flags
module fomle_alu
  import fomle_pkg::*;
(
  fomle_core_if.alu_mp aif
);

  // ----------------------------------------------------------------
  // result and flags
  // ----------------------------------------------------------------
  always_comb begin
    aif.result = aif.is_or ? (aif.accum | aif.operand) : aif.operand;
    aif.neg    = aif.result[DATA_W-1];
    aif.zero   = (aif.result == 8'h00);
  end

endmodule : fomle_alu

/* File: verilog/fomle_exec.sv */
// executes or-with-file, move-file, load-pointer and mem-to-mem move
module fomle_exec
  import fomle_pkg::*;
#(
  parameter logic [11:0] PC_LOW_ADDR = 12'hff0,  // prog_counter_low location
  parameter logic [11:0] TOS_UP_ADDR = 12'hff1,  // stack_top_upper location
  parameter logic [11:0] TOS_HI_ADDR = 12'hff2,  // stack_top_high location
  parameter logic [11:0] TOS_LO_ADDR = 12'hff3   // stack_top_low location
)(
  input  wire logic                          mclk_in,
  input  wire logic                          reset_n_in,
  input  wire logic [15:0]                   instr_in,
  input  wire logic                          instr_valid_in,
  input  wire logic [3:0]                    bank_select_reg_in,
  input  wire logic [7:0]                    mem_rdata_in,
  output logic      [1:0]                    phase_out,
  output logic      [11:0]                   mem_addr_out,
  output logic                               mem_rd_out,
  output logic      [7:0]                    mem_wdata_out,
  output logic                               mem_we_out,
  output logic      [7:0]                    accum_out,
  output logic                               flag_neg_out,
  output logic                               flag_zero_out,
  output logic      [PTR_CNT-1:0][ADDR_W-1:0] ptr_out,
  output logic                               instr_done_out,
  output logic                               seq_err_out,
  output logic                               bad_dest_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fomle_phase_type                phase_ff,     nxt_phase;      // quarter phase
  fomle_state_type                state_ff,     nxt_state;      // word sequence
  fomle_op_type                   cur_op_ff,    nxt_cur_op;     // op in this cycle
  logic                           dest_ff,      nxt_dest;       // latched d bit
  logic [1:0]                     ptr_sel_ff,   nxt_ptr_sel;    // latched pointer
  logic [11:0]                    lit_ff,       nxt_lit;        // literal staging
  logic [7:0]                     operand_ff,   nxt_operand;    // data byte read
  logic [7:0]                     accum_ff,     nxt_accum;      // accumulator
  logic                           neg_ff,       nxt_neg;        // negative flag
  logic                           zero_ff,      nxt_zero;       // zero flag
  logic [PTR_CNT-1:0][ADDR_W-1:0] ptr_ff,       nxt_ptr;        // pointers
  logic [11:0]                    mem_addr_ff,  nxt_mem_addr;   // data address
  logic                           mem_rd_ff,    nxt_mem_rd;     // read strobe
  logic [7:0]                     mem_wdata_ff, nxt_mem_wdata;  // write data
  logic                           mem_we_ff,    nxt_mem_we;     // write strobe
  logic                           done_ff,      nxt_done;       // end pulse
  logic                           err_ff,       nxt_err;        // sequence fault
  logic                           bad_ff,       nxt_bad;        // refused dest
  logic                           byte_op;                      // or / move

  fomle_core_if cif ();

  // ----------------------------------------------------------------
  // sub-units
  // ----------------------------------------------------------------
  fomle_decode u_dec (.dif (cif));
  fomle_alu    u_alu (.aif (cif));

  assign cif.instr   = instr_in;
  assign cif.accum   = accum_ff;
  assign cif.operand = operand_ff;
  assign cif.is_or   = (cur_op_ff == OP_OR);
  assign byte_op     = (cur_op_ff == OP_OR) || (cur_op_ff == OP_MOV);

  // locations the mem-to-mem move may not overwrite
  function automatic logic is_protected(input logic [11:0] a);
    is_protected = (a == PC_LOW_ADDR) || (a == TOS_UP_ADDR) ||
                   (a == TOS_HI_ADDR) || (a == TOS_LO_ADDR);
  endfunction : is_protected

  // ----------------------------------------------------------------
  // next-state logic, one quarter phase per clock
  // ----------------------------------------------------------------
  always_comb begin
    nxt_phase     = phase_ff;
    nxt_state     = state_ff;
    nxt_cur_op    = cur_op_ff;
    nxt_dest      = dest_ff;
    nxt_ptr_sel   = ptr_sel_ff;
    nxt_lit       = lit_ff;
    nxt_operand   = operand_ff;
    nxt_accum     = accum_ff;
    nxt_neg       = neg_ff;
    nxt_zero      = zero_ff;
    nxt_ptr       = ptr_ff;
    nxt_mem_addr  = mem_addr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_mem_rd    = 1'b0;                     // strobes are one phase wide
    nxt_mem_we    = 1'b0;
    nxt_done      = 1'b0;
    nxt_err       = 1'b0;
    nxt_bad       = 1'b0;
    unique case (phase_ff)
      // decode: the word on instr_in is taken at the end of q1
      PH_Q1: begin
        nxt_phase  = PH_Q2;
        nxt_cur_op = OP_NONE;
        unique case (state_ff)
          ST_IDLE: begin
            if (instr_valid_in) begin
              nxt_cur_op = cif.op;
              nxt_dest   = cif.dest;
              if (cif.op == OP_OR || cif.op == OP_MOV) begin
                nxt_mem_addr = fomle_bank_addr(cif.access, bank_select_reg_in, cif.faddr);
                nxt_mem_rd   = 1'b1;
              end
              if (cif.op == OP_MM) begin
                nxt_mem_addr = cif.lit_addr;
                nxt_mem_rd   = 1'b1;
              end
              if (cif.op == OP_LP) begin
                nxt_ptr_sel = cif.ptr_sel;
                nxt_lit     = {cif.lit_addr[3:0], 8'h00};
                if (cif.ptr_sel > 2'(PTR_CNT - 1)) begin
                  nxt_cur_op = OP_NONE;
                  nxt_err    = 1'b1;
                end
              end
            end
          end
          ST_LP2: begin
            // second word must be f0 kk
            if (instr_valid_in && cif.word2_lp) begin
              nxt_cur_op   = OP_LP;
              nxt_lit[7:0] = cif.faddr;
            end else begin
              nxt_err   = 1'b1;             // abandon, pointer keeps high nibble
              nxt_state = ST_IDLE;
            end
          end
          ST_MM2: begin
            if (instr_valid_in && cif.word2_mm) begin
              nxt_cur_op   = OP_MM;
              nxt_mem_addr = cif.lit_addr;
              nxt_bad      = is_protected(cif.lit_addr);
            end else begin
              nxt_err   = 1'b1;
              nxt_state = ST_IDLE;
            end
          end
        endcase
      end
      // read: memory answers during q2, captured at its end
      PH_Q2: begin
        nxt_phase = PH_Q3;
        if (mem_rd_ff) begin
          nxt_operand = mem_rdata_in;
        end
      end
      // process: raise the write strobe so it stands through q4
      PH_Q3: begin
        nxt_phase = PH_Q4;
        if (byte_op && dest_ff) begin
          nxt_mem_we    = 1'b1;
          nxt_mem_wdata = cif.result;
        end
        if (cur_op_ff == OP_MM && state_ff == ST_MM2 && !is_protected(mem_addr_ff)) begin
          nxt_mem_we    = 1'b1;
          nxt_mem_wdata = operand_ff;
        end
      end
      // write: results land at the end of q4
      PH_Q4: begin
        nxt_phase = PH_Q1;
        if (byte_op) begin
          nxt_done = 1'b1;
          if (!dest_ff) begin
            nxt_accum = cif.result;
          end
          nxt_neg  = cif.neg;
          nxt_zero = cif.zero;
        end
        if (cur_op_ff == OP_LP) begin
          if (state_ff == ST_IDLE) begin
            nxt_ptr[ptr_sel_ff][11:8] = lit_ff[11:8];
            nxt_state                 = ST_LP2;
          end else begin
            nxt_ptr[ptr_sel_ff][7:0] = lit_ff[7:0];
            nxt_state                = ST_IDLE;
            nxt_done                 = 1'b1;
          end
        end
        if (cur_op_ff == OP_MM) begin
          nxt_state = (state_ff == ST_IDLE) ? ST_MM2 : ST_IDLE;
          nxt_done  = (state_ff == ST_MM2);
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers, synchronous active-low reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      phase_ff     <= PH_Q1;
      state_ff     <= ST_IDLE;
      cur_op_ff    <= OP_NONE;
      dest_ff      <= 1'b0;
      ptr_sel_ff   <= 2'h0;
      lit_ff       <= PTR_RST;
      operand_ff   <= 8'h00;
      accum_ff     <= ACCUM_RST;
      neg_ff       <= 1'b0;
      zero_ff      <= 1'b0;
      ptr_ff       <= {PTR_CNT{PTR_RST}};
      mem_addr_ff  <= ADDR_RST;
      mem_rd_ff    <= 1'b0;
      mem_wdata_ff <= 8'h00;
      mem_we_ff    <= 1'b0;
      done_ff      <= 1'b0;
      err_ff       <= 1'b0;
      bad_ff       <= 1'b0;
    end else begin
      phase_ff     <= nxt_phase;
      state_ff     <= nxt_state;
      cur_op_ff    <= nxt_cur_op;
      dest_ff      <= nxt_dest;
      ptr_sel_ff   <= nxt_ptr_sel;
      lit_ff       <= nxt_lit;
      operand_ff   <= nxt_operand;
      accum_ff     <= nxt_accum;
      neg_ff       <= nxt_neg;
      zero_ff      <= nxt_zero;
      ptr_ff       <= nxt_ptr;
      mem_addr_ff  <= nxt_mem_addr;
      mem_rd_ff    <= nxt_mem_rd;
      mem_wdata_ff <= nxt_mem_wdata;
      mem_we_ff    <= nxt_mem_we;
      done_ff      <= nxt_done;
      err_ff       <= nxt_err;
      bad_ff       <= nxt_bad;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign phase_out      = phase_ff;
  assign mem_addr_out   = mem_addr_ff;
  assign mem_rd_out     = mem_rd_ff;
  assign mem_wdata_out  = mem_wdata_ff;
  assign mem_we_out     = mem_we_ff;
  assign accum_out      = accum_ff;
  assign flag_neg_out   = neg_ff;
  assign flag_zero_out  = zero_ff;
  assign ptr_out        = ptr_ff;
  assign instr_done_out = done_ff;
  assign seq_err_out    = err_ff;
  assign bad_dest_out   = bad_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_take_byte;
    phase_ff == PH_Q1 && state_ff == ST_IDLE && instr_valid_in &&
    (cif.op == OP_OR || cif.op == OP_MOV);
  endsequence
  sequence s_take_lp;
    phase_ff == PH_Q1 && state_ff == ST_IDLE && instr_valid_in && cif.op == OP_LP &&
    cif.ptr_sel != 2'h3;
  endsequence

  property p_or_accum;
    (phase_ff == PH_Q3 && cur_op_ff == OP_OR && !dest_ff) |->
      ##2 accum_ff == ($past(accum_ff, 2) | $past(operand_ff, 2));
  endproperty
  a_or_accum: assert property (p_or_accum) else $error("or result wrong");

  property p_file_dest;
    (phase_ff == PH_Q4 && byte_op && dest_ff) |-> mem_we_ff && mem_wdata_ff == cif.result;
  endproperty
  a_file_dest: assert property (p_file_dest) else $error("file write missing");

  property p_bank_sel;
    s_take_byte and instr_in[BIT_ACCESS] |->
      ##1 mem_addr_ff[11:8] == $past(bank_select_reg_in) && mem_rd_ff;
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank select ignored");

  property p_bank_reach;
    s_take_byte |-> ##1 mem_addr_ff[7:0] == $past(instr_in[7:0]);
  endproperty
  a_bank_reach: assert property (p_bank_reach) else $error("file address wrong");

  property p_move_copy;
    (phase_ff == PH_Q2 && cur_op_ff == OP_MOV && !dest_ff) |->
      ##3 accum_ff == $past(mem_rdata_in, 3);
  endproperty
  a_move_copy: assert property (p_move_copy) else $error("move altered byte");

  property p_one_cycle;
    s_take_byte |-> ##1 !done_ff [*3] ##1 done_ff;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("byte op not 1 cycle");

  property p_lp_high;
    s_take_lp |-> ##4 ptr_ff[$past(instr_in[5:4], 4)][11:8] == $past(instr_in[3:0], 4)
      && state_ff == ST_LP2;
  endproperty
  a_lp_high: assert property (p_lp_high) else $error("pointer high nibble");

  property p_lp_flags;
    cur_op_ff == OP_LP |=> $stable({neg_ff, zero_ff});
  endproperty
  a_lp_flags: assert property (p_lp_flags) else $error("flags moved");

  property p_mm_refuse;
    (phase_ff == PH_Q1 && state_ff == ST_MM2 && instr_valid_in && cif.word2_mm &&
     is_protected(cif.lit_addr)) |-> ##1 bad_ff ##2 !mem_we_ff;
  endproperty
  a_mm_refuse: assert property (p_mm_refuse) else $error("protected write");

  property p_flags;
    (phase_ff == PH_Q4 && byte_op) |=>
      zero_ff == ($past(cif.result) == 8'h00) && neg_ff == $past(cif.result[7]);
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");

endmodule : fomle_exec

/* File: verification/fomle_tb_top.sv */
module fomle_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fomle_pkg::*;
  // ----------------------------------------------------------------
  // design ports and reference state
  // ----------------------------------------------------------------
  logic                   mclk_in, reset_n_in, instr_valid_in;
  logic [15:0]            instr_in;
  logic [3:0]             bank_select_reg_in;
  logic [7:0]             mem_rdata_in, mem_wdata_out, accum_out;
  logic [1:0]             phase_out;
  logic [11:0]            mem_addr_out;
  logic                   mem_rd_out, mem_we_out, flag_neg_out, flag_zero_out;
  logic                   instr_done_out, seq_err_out, bad_dest_out;
  logic [2:0][11:0]       ptr_out, rp;       // design / reference pointers
  logic [7:0]             mem [4096];        // reference data memory
  logic [7:0]             acc;               // reference accumulator
  logic                   rn, rz;            // reference flags
  logic [45:0]            exp_q [$];         // state expected at each done pulse
  logic [19:0]            wr_q [$];          // address and byte of each write
  int                     num_errors, compares, n_err, n_bad, x_err, x_bad;
  // ram answers at once, as the read strobe only qualifies the address
  assign mem_rdata_in = mem[mem_addr_out];
  fomle_exec u_fomle_exec (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .bank_select_reg_in(bank_select_reg_in),
    .mem_rdata_in(mem_rdata_in), .phase_out(phase_out), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out),
    .accum_out(accum_out), .flag_neg_out(flag_neg_out), .flag_zero_out(flag_zero_out),
    .ptr_out(ptr_out), .instr_done_out(instr_done_out), .seq_err_out(seq_err_out),
    .bad_dest_out(bad_dest_out));
  // ----------------------------------------------------------------
  // clock, compare and closing
  // ----------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // drivers: one word per instruction cycle, presented in q1
  // ----------------------------------------------------------------
  task automatic issue(input logic [15:0] w, input logic v, input logic [3:0] b);
    do @(negedge mclk_in); while (phase_out !== 2'h3);
    @(posedge mclk_in);
    instr_in <= w;
    instr_valid_in <= v;
    bank_select_reg_in <= b;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    instr_in <= 16'($urandom);  // junk outside q1 must be ignored
    @(posedge mclk_in);
    @(negedge mclk_in);         // operand read is over, model may move on
  endtask : issue
  task automatic note();
    exp_q.push_back({acc, rn, rz, rp});
  endtask : note
  task automatic byte_op(input logic o, input logic d, input logic a, input logic [7:0] f);
    logic [3:0] b;
    logic [11:0] ad;
    logic [7:0] r;
    b = 4'($urandom);
    ad = a ? {b, f} : (f < 8'h80 ? {4'h0, f} : {4'hf, f});
    r = o ? (acc | mem[ad]) : mem[ad];
    issue({o ? 6'h04 : 6'h14, d, a, f}, 1'b1, b);
    if (d) begin
      wr_q.push_back({ad, r});
      mem[ad] = r;
    end else begin
      acc = r;
    end
    rn = r[7];
    rz = (r == 8'h00);
    note();
  endtask : byte_op
  // pointer load, w2 low drops the second word
  task automatic lp(input logic [1:0] s, input logic [11:0] k, input logic w2);
    issue({8'hee, 2'h0, s, k[11:8]}, 1'b1, 4'h0);
    if (s == 2'h3) begin
      x_err++;
      return;
    end
    rp[s][11:8] = k[11:8];
    issue({8'hf0, k[7:0]}, w2, 4'h0);
    if (!w2) begin
      x_err++;
      return;
    end
    rp[s][7:0] = k[7:0];
    note();
  endtask : lp
  task automatic mm(input logic [11:0] s, input logic [11:0] d);
    logic [7:0] v;
    v = mem[s];
    issue({4'hc, s}, 1'b1, 4'h0);
    issue({4'hf, d}, 1'b1, 4'h0);
    if (d inside {12'hff0, 12'hff1, 12'hff2, 12'hff3}) begin
      x_bad++;
    end else begin
      wr_q.push_back({d, v});
      mem[d] = v;
    end
    note();
  endtask : mm
  // ----------------------------------------------------------------
  // watcher: takes the oldest note whenever a result shows
  // ----------------------------------------------------------------
  always @(negedge mclk_in) begin
    if (instr_done_out === 1'b1) begin
      chk({accum_out, flag_neg_out, flag_zero_out, ptr_out}, exp_q.pop_front());
      chk(phase_out, 2'h0);
    end
    if (mem_we_out === 1'b1) begin
      chk({mem_addr_out, mem_wdata_out}, wr_q.pop_front());
      chk(phase_out, 2'h3);
    end
    if (mem_rd_out === 1'b1) begin
      chk(phase_out, 2'h1);
    end
    if (seq_err_out === 1'b1) n_err++;
    if (bad_dest_out === 1'b1) n_bad++;
  end
  initial begin
    #(100 * 20000);
    num_errors++;
    test_done();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(2468));
    {reset_n_in, instr_valid_in, instr_in, bank_select_reg_in} = '0;
    {acc, rn, rz, rp, num_errors, compares, n_err, n_bad, x_err, x_bad} = '0;
    foreach (mem[i]) mem[i] = 8'($urandom);
    mem[12'h005] = 8'h00;
    repeat (10) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(negedge mclk_in);
    chk({accum_out, flag_neg_out, flag_zero_out, ptr_out}, 46'h0);
    for (int i = 0; i < 8; i++) byte_op(i[0], i[1], i[2], 8'($urandom));
    byte_op(1'b1, 1'b0, 1'b0, 8'h7f);
    byte_op(1'b1, 1'b0, 1'b0, 8'h80);
    byte_op(1'b0, 1'b1, 1'b1, 8'hff);
    byte_op(1'b0, 1'b0, 1'b0, 8'h05);
    for (int s = 0; s < 3; s++) lp(2'(s), 12'($urandom), 1'b1);
    lp(2'h2, 12'hfff, 1'b1);
    lp(2'h3, 12'h123, 1'b1);
    issue(16'h0000, 1'b0, 4'h0);
    lp(2'h1, 12'habc, 1'b0);
    byte_op(1'b0, 1'b0, 1'b0, 8'h05);
    mm(12'h000, 12'hfff);
    for (int i = 0; i < 4; i++) mm(12'($urandom), 12'hff0 + 12'(i));
    repeat (40) begin
      case ($urandom % 3)
        0: byte_op(1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom));
        1: lp(2'($urandom % 3), 12'($urandom), 1'b1);
        default: mm(12'($urandom), 12'($urandom));
      endcase
    end
    repeat (12) @(posedge mclk_in);
    chk(n_err, x_err);
    chk(n_bad, x_bad);
    chk(exp_q.size() + wr_q.size(), 0);
    test_done();
  end
endmodule : fomle_tb_top
